// ### src/axc_pkg.sv
// Purpose: shared constants and types of the auxiliary converter control block
// Assumes: 250 MHz master clock, registers reached through the plain register port
// Notes: settle-wait figures between the two ends are plain defaults
package axc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned WAIT_CNT_W = 21;
  localparam int unsigned SETTLE_US [8] = '{0, 32, 128, 320, 800, 1600, 4000, 8000};
  localparam int unsigned DOUT_RETURN_NS = 20;
  localparam int unsigned DOUT_RETURN_CYC = (DOUT_RETURN_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                            (DOUT_RETURN_NS / CLK_PERIOD_NS);
  localparam int unsigned DOUT_CNT_W = 8;
  typedef int unsigned axc_wait_tab_type [8];

  // ----------------------------------------------------------------
  // register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_CONV_MODE = 6'h01;
  localparam logic [5:0] ADDR_IF_MODE = 6'h02;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  localparam logic [5:0] ADDR_AUX_CFG = 6'h06;
  localparam logic [15:0] CONV_MODE_RST = 16'h0000;
  localparam logic [15:0] IF_MODE_RST = 16'h0000;
  localparam logic [15:0] AUX_CFG_RST = 16'h0800;
  localparam logic [15:0] AUX_WATCH_MASK = 16'hFEFC;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CM_ABSORB_BIT = 14;
  localparam int unsigned CM_WAIT_LSB = 8;
  localparam int unsigned IF_SHORT_BIT = 0;
  localparam int unsigned IF_HOLD_BIT = 1;
  localparam int unsigned IF_STEP_BIT = 2;
  localparam int unsigned IF_WATCH_BIT = 3;
  localparam int unsigned AUX_SELTIME_BIT = 12;
  localparam int unsigned AUX_SYNCSEL_BIT = 11;
  localparam int unsigned AUX_FFUNC_LSB = 9;
  localparam int unsigned AUX_FLEVEL_BIT = 8;
  localparam int unsigned AUX_INEN_LSB = 4;
  localparam int unsigned AUX_OUTEN_LSB = 2;
  localparam int unsigned AUX_LEVEL_LSB = 0;

  // ----------------------------------------------------------------
  // output-rate limits in hundredths of a sample per second
  // ----------------------------------------------------------------
  localparam int unsigned RATE_ABSORB_LIMIT = 260000;
  localparam int unsigned RATE_NO_ABSORB [4] = '{38100, 5952, 4968, 1666};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPF_OFF = 2'b00,
    FPF_INPUT = 2'b01,
    FPF_OPEN_DRAIN = 2'b10,
    FPF_OUTPUT = 2'b11
  } axc_fault_fn_type;

  typedef enum logic [1:0] {
    ST_HELD = 2'b00,
    ST_SETTLE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_WAIT = 2'b11
  } axc_state_type;

  function automatic axc_wait_tab_type settle_table();
    axc_wait_tab_type t;
    for (int i = 0; i < 8; i++) begin
      t[i] = SETTLE_US[i] * CLK_MHZ;
    end
    return t;
  endfunction : settle_table

  function automatic logic rate_no_absorb(input logic [23:0] rate);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (32'(rate) == RATE_NO_ABSORB[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : rate_no_absorb

  function automatic logic [7:0] fold8(input logic [31:0] v);
    return v[31:24] ^ v[23:16] ^ v[15:8] ^ v[7:0];
  endfunction : fold8

endpackage : axc_pkg

// ### src/axc_timer_if.sv
// Purpose: link between the control logic and the settle-wait timer
// Assumes: one master clock
// Notes: start is a one-cycle pulse
`timescale 1ns/1ps
interface axc_timer_if;
  logic start;
  logic [20:0] cycles;
  logic busy;
  logic done;
  modport ctl (output start, output cycles, input busy, input done);
  modport tmr (input start, input cycles, output busy, output done);
endinterface : axc_timer_if

// ### src/axc_settle_timer.sv
// Purpose: counts the settle wait before sampling
// Assumes: cycles is stable on the start pulse
// Notes: done pulses two cycles after start for a zero wait
`timescale 1ns/1ps
module axc_settle_timer
  import axc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  axc_timer_if.tmr tif
);

  logic [WAIT_CNT_W-1:0] cnt_reg;
  logic busy_reg;
  logic done_reg;

  assign tif.busy = busy_reg;
  assign tif.done = done_reg;

  // ----------------------------------------------------------------
  // countdown
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tif.start) begin
        cnt_reg <= tif.cycles;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg == '0) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_wait_zero_done: assert property ((tif.start && tif.cycles == '0) |=> busy_reg ##1 done_reg)
    else $error("zero settle wait did not finish in two cycles");

endmodule : axc_settle_timer

// ### src/axc_xor_check.sv
// Purpose: bytewise exclusive-or check value of a read transaction
// Assumes: start coincides with the command byte slot or precedes it
// Notes: sum holds until the next valid byte or start
`timescale 1ns/1ps
module axc_xor_check
  import axc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  output logic [7:0] sum_o
);

  logic [7:0] sum_reg;
  assign sum_o = sum_reg;

  // ----------------------------------------------------------------
  // accumulate
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sum_reg <= 8'h00;
    end else if (start_i) begin
      sum_reg <= byte_valid_i ? byte_i : 8'h00;
    end else if (byte_valid_i) begin
      sum_reg <= sum_reg ^ byte_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_xor_two_bytes: assert property ((start_i && byte_valid_i) ##1 (byte_valid_i && !start_i)
                                      |=> sum_reg == ($past(byte_i, 2) ^ $past(byte_i)))
    else $error("check value is not the xor of the bytes");

endmodule : axc_xor_check

// ### src/axc_top.sv
// Purpose: auxiliary pin, settle wait, sync, result width and fault flag logic
// Assumes: serial framing decoded outside; inputs synchronous to SYS_CLK_I except SYNC_FAULT_I, which is double-registered
// Notes: registers reached through the plain register port
`timescale 1ns/1ps
module axc_top
  import axc_pkg::*;
#(
  parameter axc_wait_tab_type SETTLE_CYC = settle_table()
) (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [5:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  output logic [23:0] REG_RDATA_O,
  input wire logic XFER_START_I,
  input wire logic XFER_BYTE_VALID_I,
  input wire logic [7:0] XFER_BYTE_I,
  output logic [7:0] READ_CHECK_O,
  input wire logic WR_CHECK_FAIL_I,
  input wire logic CS_N_I,
  input wire logic READ_ACTIVE_I,
  input wire logic READ_BIT_I,
  input wire logic READ_END_I,
  input wire logic DATA_READ_DONE_I,
  output logic DOUT_RDY_O,
  input wire logic SYNC_FAULT_I,
  output logic SYNC_FAULT_O,
  output logic SYNC_FAULT_OE_O,
  input wire logic AUX_PIN_ZERO_I,
  output logic AUX_PIN_ZERO_O,
  output logic AUX_PIN_ZERO_OE_O,
  input wire logic AUX_PIN_ONE_I,
  output logic AUX_PIN_ONE_O,
  output logic AUX_PIN_ONE_OE_O,
  input wire logic CONV_DONE_I,
  input wire logic [23:0] CONV_RESULT_I,
  input wire logic RANGE_FAULT_I,
  input wire logic OVERVOLT_I,
  input wire logic UNDERVOLT_I,
  input wire logic [1:0] CHAN_LAST_I,
  input wire logic FILTER_SINC5_I,
  input wire logic [23:0] RATE_CSPS_I,
  input wire logic [23:0] CONV_TIME_US_I,
  output logic FILTER_RESET_O,
  output logic SAMPLE_START_O,
  output logic [1:0] CHAN_SEL_O,
  output logic CHAN_NEXT_O,
  output logic WAIT_ABSORBED_O
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] conv_mode_reg;
  logic [15:0] if_mode_reg;
  logic [15:0] aux_cfg_reg;
  logic [23:0] data_reg;
  logic rdy_n_reg, conv_fault_reg, crc_fault_reg, cfg_fault_reg;
  logic [7:0] cfg_snap_reg;
  logic [1:0] aux_level_reg;
  logic [23:0] rdata_reg;
  logic sync_s1_reg, sync_s2_reg;
  axc_state_type state_reg, state_next;
  logic sample_start_reg, chan_next_reg, absorbed_reg;
  logic [1:0] chan_reg;
  logic dout_reg, last_bit_reg, hold_reg;
  logic [DOUT_CNT_W-1:0] dout_cnt_reg;

  wire wr_conv = REG_WR_I && REG_ADDR_I == ADDR_CONV_MODE;
  wire wr_if = REG_WR_I && REG_ADDR_I == ADDR_IF_MODE;
  wire wr_aux = REG_WR_I && REG_ADDR_I == ADDR_AUX_CFG;
  wire rd_status = REG_RD_I && REG_ADDR_I == ADDR_STATUS;
  wire [2:0] wait_sel = conv_mode_reg[CM_WAIT_LSB +: 3];
  wire sync_sel = aux_cfg_reg[AUX_SYNCSEL_BIT];
  wire [1:0] ffunc = aux_cfg_reg[AUX_FFUNC_LSB +: 2];
  wire short_mode = if_mode_reg[IF_SHORT_BIT];
  wire watch_en = if_mode_reg[IF_WATCH_BIT];
  wire step_mode = sync_sel && if_mode_reg[IF_STEP_BIT] && CHAN_LAST_I != 2'b00;
  wire hold_reset = sync_sel && !step_mode && !sync_s2_reg;
  wire ext_fault = !sync_sel && ffunc == FPF_INPUT && !sync_s2_reg;
  wire any_fault = conv_fault_reg || crc_fault_reg || cfg_fault_reg;
  wire [7:0] status_byte = {rdy_n_reg, conv_fault_reg, crc_fault_reg, cfg_fault_reg, 2'b00, chan_reg};
  wire [7:0] cfg_sig = fold8({conv_mode_reg, aux_cfg_reg & AUX_WATCH_MASK});
  wire [1:0] aux_pin_in = {AUX_PIN_ONE_I, AUX_PIN_ZERO_I};
  wire [1:0] aux_out_en = aux_cfg_reg[AUX_OUTEN_LSB +: 2];
  wire [1:0] aux_in_en = aux_cfg_reg[AUX_INEN_LSB +: 2];
  logic [1:0] aux_drive;

  // ----------------------------------------------------------------
  // register writes and reads
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      conv_mode_reg <= CONV_MODE_RST;
      if_mode_reg <= IF_MODE_RST;
      aux_cfg_reg <= AUX_CFG_RST;
    end else begin
      if (wr_conv) begin
        conv_mode_reg <= REG_WDATA_I;
      end
      if (wr_if) begin
        if_mode_reg <= REG_WDATA_I;
      end
      if (wr_aux) begin
        aux_cfg_reg <= REG_WDATA_I;
      end
      if (!sync_sel && ffunc == FPF_INPUT) begin
        aux_cfg_reg[AUX_FLEVEL_BIT] <= sync_s2_reg;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      rdata_reg <= 24'h000000;
    end else if (REG_RD_I) begin
      case (REG_ADDR_I)
        ADDR_STATUS: rdata_reg <= {16'h0000, status_byte};
        ADDR_CONV_MODE: rdata_reg <= {8'h00, conv_mode_reg};
        ADDR_IF_MODE: rdata_reg <= {8'h00, if_mode_reg};
        ADDR_DATA: rdata_reg <= data_reg;
        ADDR_AUX_CFG: rdata_reg <= {8'h00, aux_cfg_reg[15:2], aux_level_reg};
        default: rdata_reg <= 24'h000000;
      endcase
    end
  end
  assign REG_RDATA_O = rdata_reg;

  // ----------------------------------------------------------------
  // auxiliary pins
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_aux
    always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
        aux_level_reg[g] <= AUX_CFG_RST[AUX_LEVEL_LSB + g];
      end else if (aux_in_en[g]) begin
        aux_level_reg[g] <= aux_pin_in[g];
      end else if (wr_aux) begin
        aux_level_reg[g] <= REG_WDATA_I[AUX_LEVEL_LSB + g];
      end
    end
    assign aux_drive[g] = aux_cfg_reg[AUX_SELTIME_BIT] ? chan_reg[g] : aux_level_reg[g];
  end
  assign AUX_PIN_ZERO_O = aux_drive[0];
  assign AUX_PIN_ONE_O = aux_drive[1];
  assign AUX_PIN_ZERO_OE_O = aux_out_en[0];
  assign AUX_PIN_ONE_OE_O = aux_out_en[1];

  // ----------------------------------------------------------------
  // sync/fault pin
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      sync_s1_reg <= 1'b1;
      sync_s2_reg <= 1'b1;
    end else begin
      sync_s1_reg <= SYNC_FAULT_I;
      sync_s2_reg <= sync_s1_reg;
    end
  end

  always_comb begin
    SYNC_FAULT_O = 1'b0;
    SYNC_FAULT_OE_O = 1'b0;
    if (!sync_sel) begin
      case (ffunc)
        FPF_OPEN_DRAIN: SYNC_FAULT_OE_O = any_fault;
        FPF_OUTPUT: begin
          SYNC_FAULT_OE_O = 1'b1;
          SYNC_FAULT_O = aux_cfg_reg[AUX_FLEVEL_BIT];
        end
        default: SYNC_FAULT_OE_O = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  axc_timer_if tif ();
  axc_settle_timer u_timer (.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .tif(tif));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_HELD: if (!hold_reset) state_next = ST_SETTLE;
      ST_SETTLE: if (tif.done) state_next = ST_CONVERT;
      ST_CONVERT: if (CONV_DONE_I) state_next = (step_mode && !sync_s2_reg) ? ST_WAIT : ST_SETTLE;
      ST_WAIT: if (!step_mode || sync_s2_reg) state_next = ST_SETTLE;
      default: state_next = ST_HELD;
    endcase
    if (hold_reset) begin
      state_next = ST_HELD;
    end
  end
  assign tif.start = state_next == ST_SETTLE && state_reg != ST_SETTLE;
  assign tif.cycles = WAIT_CNT_W'(SETTLE_CYC[wait_sel]);

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      state_reg <= ST_HELD;
      sample_start_reg <= 1'b0;
      chan_next_reg <= 1'b0;
      chan_reg <= 2'b00;
    end else begin
      state_reg <= state_next;
      sample_start_reg <= state_reg == ST_SETTLE && tif.done && !hold_reset;
      chan_next_reg <= 1'b0;
      if (state_reg == ST_CONVERT && CONV_DONE_I && !hold_reset) begin
        chan_reg <= chan_reg == CHAN_LAST_I ? 2'b00 : chan_reg + 2'b01;
        chan_next_reg <= 1'b1;
      end
    end
  end
  assign FILTER_RESET_O = state_reg == ST_HELD;
  assign SAMPLE_START_O = sample_start_reg;
  assign CHAN_SEL_O = chan_reg;
  assign CHAN_NEXT_O = chan_next_reg;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      absorbed_reg <= 1'b0;
    end else begin
      absorbed_reg <= FILTER_SINC5_I && conv_mode_reg[CM_ABSORB_BIT] && wait_sel != 3'b000
                      && (SETTLE_US[wait_sel] * 2) < 32'(CONV_TIME_US_I)
                      && 32'(RATE_CSPS_I) < RATE_ABSORB_LIMIT && !rate_no_absorb(RATE_CSPS_I);
    end
  end
  assign WAIT_ABSORBED_O = absorbed_reg;

  // ----------------------------------------------------------------
  // result, ready and flags
  // ----------------------------------------------------------------
  wire [16:0] rounded = {1'b0, CONV_RESULT_I[23:8]} + {16'h0000, CONV_RESULT_I[7]};
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      data_reg <= 24'h000000;
      rdy_n_reg <= 1'b1;
    end else begin
      if (DATA_READ_DONE_I) begin
        rdy_n_reg <= 1'b1;
      end
      if (state_reg == ST_CONVERT && CONV_DONE_I) begin
        rdy_n_reg <= 1'b0;
        if (OVERVOLT_I) begin
          data_reg <= short_mode ? 24'h00FFFF : 24'hFFFFFF;
        end else if (UNDERVOLT_I) begin
          data_reg <= 24'h000000;
        end else if (short_mode) begin
          data_reg <= {8'h00, rounded[16] ? 16'hFFFF : rounded[15:0]};
        end else begin
          data_reg <= CONV_RESULT_I;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      conv_fault_reg <= 1'b0;
      crc_fault_reg <= 1'b0;
      cfg_fault_reg <= 1'b0;
      cfg_snap_reg <= 8'h00;
    end else begin
      if ((CONV_DONE_I && RANGE_FAULT_I) || OVERVOLT_I || UNDERVOLT_I || ext_fault) begin
        conv_fault_reg <= 1'b1;
      end else if (!RANGE_FAULT_I) begin
        conv_fault_reg <= 1'b0;
      end
      if (WR_CHECK_FAIL_I) begin
        crc_fault_reg <= 1'b1;
      end else if (rd_status) begin
        crc_fault_reg <= 1'b0;
      end
      if (!watch_en) begin
        cfg_snap_reg <= cfg_sig;
      end
      if (wr_if && !REG_WDATA_I[IF_WATCH_BIT]) begin
        cfg_fault_reg <= 1'b0;
      end else if (watch_en && cfg_sig != cfg_snap_reg) begin
        cfg_fault_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared out/ready pin
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_I) begin
    if (!RSTN_I) begin
      dout_reg <= 1'b1;
      last_bit_reg <= 1'b1;
      hold_reg <= 1'b0;
      dout_cnt_reg <= '0;
    end else begin
      if (READ_ACTIVE_I) begin
        last_bit_reg <= READ_BIT_I;
        dout_reg <= READ_BIT_I;
        hold_reg <= 1'b0;
      end else if (READ_END_I) begin
        hold_reg <= 1'b1;
        dout_cnt_reg <= DOUT_CNT_W'(DOUT_RETURN_CYC);
        dout_reg <= last_bit_reg;
      end else if (hold_reg && (if_mode_reg[IF_HOLD_BIT] ? !CS_N_I : dout_cnt_reg > 1)) begin
        dout_cnt_reg <= dout_cnt_reg - 1'b1;
        dout_reg <= last_bit_reg;
      end else begin
        hold_reg <= 1'b0;
        dout_reg <= CS_N_I ? 1'b1 : rdy_n_reg;
      end
    end
  end
  assign DOUT_RDY_O = dout_reg;

  axc_xor_check u_xor (
    .clk_i(SYS_CLK_I),
    .rstn_i(RSTN_I),
    .start_i(XFER_START_I),
    .byte_valid_i(XFER_BYTE_VALID_I),
    .byte_i(XFER_BYTE_I),
    .sum_o(READ_CHECK_O)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  chk_crc_set_wins: assert property (WR_CHECK_FAIL_I |=> crc_fault_reg ##1 (crc_fault_reg || $past(rd_status)))
    else $error("checksum fault not set by bad write");
  chk_crc_read_clr: assert property ((rd_status && !WR_CHECK_FAIL_I) |=> !crc_fault_reg)
    else $error("checksum fault not cleared by status read");
  chk_short_word: assert property ((state_reg == ST_CONVERT && CONV_DONE_I && short_mode) |=> data_reg[23:16] == 8'h00)
    else $error("short result wider than 16 bits");
  chk_gp_fault_pin: assert property ((!sync_sel && ffunc == FPF_OUTPUT) |-> (SYNC_FAULT_OE_O && SYNC_FAULT_O == aux_cfg_reg[AUX_FLEVEL_BIT]))
    else $error("fault pin does not follow level bit");
  chk_od_fault_pin: assert property ((!sync_sel && ffunc == FPF_OPEN_DRAIN && any_fault) |-> (SYNC_FAULT_OE_O && !SYNC_FAULT_O))
    else $error("open-drain fault output not pulled low");
  chk_sync_hold: assert property ((sync_sel && !step_mode && !sync_s2_reg) [*2] |-> FILTER_RESET_O && !SAMPLE_START_O)
    else $error("filter not held reset while sync low");
  chk_ready_fall: assert property ((state_reg == ST_CONVERT && CONV_DONE_I && !hold_reset) |=> !rdy_n_reg && chan_next_reg)
    else $error("ready did not fall after conversion");
  chk_watch_clear: assert property ((wr_if && !REG_WDATA_I[IF_WATCH_BIT]) |=> !cfg_fault_reg)
    else $error("config fault not cleared by disabling watch");
  chk_absorb_rate: assert property (($past(32'(RATE_CSPS_I)) >= RATE_ABSORB_LIMIT) |-> !WAIT_ABSORBED_O)
    else $error("wait absorbed at a fast output rate");

endmodule : axc_top

// ### bench/axc_host_model.sv
// Purpose: host side of the sync/fault pin
// Assumes: pin carries a pull-up
// Notes: host moves its level on rising clock edges only
`timescale 1ns/1ps
module axc_host_model
  import axc_pkg::*;
(
  input wire logic clk_i,
  input wire logic drive_i,
  input wire logic low_i,
  input wire logic dev_o_i,
  input wire logic dev_oe_i,
  output logic pin_o
);
  logic lvl_reg = 1'b1;
  always_ff @(posedge clk_i) lvl_reg <= ~low_i;
  assign pin_o = dev_oe_i ? dev_o_i : (drive_i ? lvl_reg : 1'b1);
endmodule : axc_host_model

// ### bench/testbench.sv
// Purpose: self-checking bench of the auxiliary control block
// Assumes: short settle table, host model on the sync/fault pin
// Notes: register port driven on rising edges
`timescale 1ns/1ps
module testbench;
  import axc_pkg::*;
  localparam axc_wait_tab_type TAB = '{0, 2, 4, 8, 16, 32, 64, 128};
  logic clk = 0, rstn = 0, wr = 0, rd = 0, xs = 0, xv = 0, wf = 0, csn = 0, ra = 0, rb = 0, re = 0, rdd = 0;
  logic lo = 0, hd = 1, e0 = 0, e1 = 1, cd = 0, rg = 0, ov = 0, uv = 0, s5 = 1;
  logic [5:0] ad = 6'h00;
  logic [15:0] wd = 16'h0000;
  logic [7:0] xb = 8'h00, ck;
  logic [23:0] res = 24'h000000, rdat, d;
  logic [1:0] cl = 2'h0;
  logic dout, so, soe, p0, p0oe, p1, p1oe, pin, frst, ss;
  logic [5:0] rad [4] = '{6'h01, 6'h06, 6'h00, 6'h03};
  logic [23:0] rv [4] = '{24'h000000, 24'h000800, 24'h000080, 24'h000000};
  logic [7:0] xby [3] = '{8'h65, 8'h43, 8'h21};
  int bad_count = 0, checked = 0, n0, n3;
  axc_host_model i_axc_host_model (.clk_i(clk), .drive_i(hd), .low_i(lo), .dev_o_i(so), .dev_oe_i(soe), .pin_o(pin));
  axc_top #(.SETTLE_CYC(TAB)) i_axc_top (.SYS_CLK_I(clk), .RSTN_I(rstn), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(ad), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .XFER_START_I(xs), .XFER_BYTE_VALID_I(xv),
    .XFER_BYTE_I(xb), .READ_CHECK_O(ck), .WR_CHECK_FAIL_I(wf), .CS_N_I(csn), .READ_ACTIVE_I(ra),
    .READ_BIT_I(rb), .READ_END_I(re), .DATA_READ_DONE_I(rdd), .DOUT_RDY_O(dout), .SYNC_FAULT_I(pin),
    .SYNC_FAULT_O(so), .SYNC_FAULT_OE_O(soe), .AUX_PIN_ZERO_I(p0oe ? p0 : e0), .AUX_PIN_ZERO_O(p0),
    .AUX_PIN_ZERO_OE_O(p0oe), .AUX_PIN_ONE_I(p1oe ? p1 : e1), .AUX_PIN_ONE_O(p1), .AUX_PIN_ONE_OE_O(p1oe),
    .CONV_DONE_I(cd), .CONV_RESULT_I(res), .RANGE_FAULT_I(rg), .OVERVOLT_I(ov), .UNDERVOLT_I(uv),
    .CHAN_LAST_I(cl), .FILTER_SINC5_I(s5), .RATE_CSPS_I(24'h0186A0), .CONV_TIME_US_I(24'h0003E8),
    .FILTER_RESET_O(frst), .SAMPLE_START_O(ss), .CHAN_SEL_O(), .CHAN_NEXT_O(), .WAIT_ABSORBED_O());
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= w;
    rd <= ~w;
    ad <= a;
    wd <= v;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    @(posedge clk);
    #1 d = rdat;
  endtask : acc
  task automatic rd_bit(input logic b);
    @(posedge clk);
    ra <= 1;
    rb <= b;
    @(posedge clk);
    ra <= 0;
    re <= 1;
    @(posedge clk);
    re <= 0;
    repeat (8) @(posedge clk);
    #1;
  endtask : rd_bit
  task automatic sync_run(output int n);
    @(posedge clk);
    lo <= 1;
    repeat (8) @(posedge clk);
    #1 chk("filter held", frst, 1);
    @(posedge clk);
    lo <= 0;
    n = 0;
    while (ss !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : sync_run
  task automatic tally_and_finish;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    #20000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1;
    foreach (rad[i]) begin
      acc(0, rad[i], 16'h0000);
      chk("reset value", d, rv[i]);
    end
    foreach (xby[i]) begin
      @(posedge clk);
      xs <= (i == 0);
      xv <= 1;
      xb <= xby[i];
    end
    @(posedge clk);
    xv <= 0;
    repeat (2) @(posedge clk);
    #1 chk("read check", ck, 8'h07);
    acc(1, 6'h06, 16'h080D);
    chk("aux drive", {p1oe, p1, p0oe, p0}, 4'hB);
    acc(1, 6'h06, 16'h0830);
    acc(0, 6'h06, 16'h0000);
    chk("aux sample", d[1:0], 2'h2);
    $display("register and pin tests done");
    acc(1, 6'h06, 16'h0800);
    sync_run(n0);
    acc(1, 6'h01, 16'h0300);
    sync_run(n3);
    chk("settle wait", 24'(n3 - n0), 24'(TAB[3]));
    @(posedge clk);
    cd <= 1;
    res <= 24'h123456;
    @(posedge clk);
    cd <= 0;
    repeat (2) @(posedge clk);
    #1 chk("ready low", dout, 1'b0);
    acc(0, 6'h04, 16'h0000);
    chk("result", d, 24'h123456);
    $display("sync test done");
    rd_bit(1);
    chk("ready after read", dout, 1'b0);
    @(posedge clk);
    rdd <= 1;
    @(posedge clk);
    rdd <= 0;
    repeat (2) @(posedge clk);
    #1 chk("ready high", dout, 1'b1);
    acc(1, 6'h02, 16'h0002);
    rd_bit(0);
    chk("held bit", dout, 1'b0);
    @(posedge clk);
    csn <= 1;
    repeat (2) @(posedge clk);
    #1 chk("released", dout, 1'b1);
    $display("out pin test done");
    acc(1, 6'h06, 16'h0700);
    chk("fault pin out", {soe, so}, 2'h3);
    @(posedge clk);
    hd <= 0;
    wf <= 1;
    @(posedge clk);
    wf <= 0;
    acc(1, 6'h06, 16'h0400);
    chk("fault pin low", {soe, so}, 2'h2);
    acc(0, 6'h00, 16'h0000);
    chk("crc flag", d[5], 1'b1);
    chk("fault pin free", {soe, pin}, 2'h1);
    acc(1, 6'h02, 16'h0008);
    acc(1, 6'h01, 16'h0100);
    acc(0, 6'h00, 16'h0000);
    chk("watch flag set", d[4], 1'b1);
    acc(1, 6'h02, 16'h0000);
    acc(0, 6'h00, 16'h0000);
    chk("watch flag clear", d[4], 1'b0);
    $display("fault test done");
    tally_and_finish();
  end
endmodule : testbench
